// File: design/mapt_ctl.sv
`timescale 1ns/1ps
`include "mapt_map.svh"
module mapt_ctl
  import mapt_pkg::*;
(
  input  wire logic                    core_clk,
  input  wire logic                    rst_n,
  mapt_link_if.ctl                     link,
  input  wire mapt_mode_t              user_mode,
  input  wire logic                    user_run,
  input  wire logic                    user_fire,
  input  wire logic                    user_clear,
  input  wire logic [`MAPT_NCNT_W-1:0] count_n,
  output logic                         count_done
);
  import mapt_pkg::*;

  mapt_ctl_t r;
  mapt_ctl_t n;
  logic      q_rise;

  // wiring per mode; the external N counter lives here
  always_comb begin
    n        = r;
    q_rise   = link.pulse_q & ~r.q_prev;
    n.q_prev = link.pulse_q;
    n.gate   = 1'b0;
    n.gate_n = 1'b1;
    n.rise   = 1'b0;
    n.fall   = 1'b0;
    n.extend = 1'b0;
    n.clear  = user_clear;
    case (user_mode)
      MAPT_M_FREE:  n.gate   = 1'b1;
      MAPT_M_TGATE: n.gate   = user_run;
      MAPT_M_CGATE: n.gate_n = ~user_run;
      MAPT_M_RISE:  n.rise   = user_fire;
      MAPT_M_FALL: begin
        n.rise = 1'b1;
        n.fall = user_fire;
      end
      MAPT_M_RETRG: begin
        n.rise   = user_fire;
        n.extend = user_fire;
      end
      MAPT_M_COUNT: begin
        // trigger clears the counter; each Q rise counts; the (N+1)th stops it
        if (user_fire) begin
          n.ncnt = `MAPT_NCNT_FULL - `MAPT_NCNT_FULL;
        end else if (q_rise && !r.done) begin
          n.ncnt = r.ncnt + `MAPT_NCNT_ONE;
        end
        n.gate_n = n.done;
      end
      default: n.gate = 1'b0;
    endcase
    n.done = (n.ncnt > count_n);
    if (user_mode == MAPT_M_COUNT) begin
      n.gate_n = n.done;
    end
  end

  // clear comes out of reset high so the timer starts quiet
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      r.gate   <= 1'b0;
      r.gate_n <= 1'b1;
      r.rise   <= 1'b0;
      r.fall   <= 1'b0;
      r.extend <= 1'b0;
      r.clear  <= 1'b1;
      r.q_prev <= 1'b0;
      r.ncnt   <= `MAPT_NCNT_FULL;
      r.done   <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign link.run_gate   = r.gate;
  assign link.run_gate_n = r.gate_n;
  assign link.fire_rise  = r.rise;
  assign link.fire_fall  = r.fall;
  assign link.extend     = r.extend;
  assign link.ext_clear  = r.clear;
  assign count_done      = r.done;
endmodule : mapt_ctl

// File: design/mapt_link_if.sv
`timescale 1ns/1ps
interface mapt_link_if;
  logic run_gate;
  logic run_gate_n;
  logic fire_rise;
  logic fire_fall;
  logic extend;
  logic ext_clear;
  logic pulse_q;
  logic pulse_q_n;
  logic osc_out;

  modport dev (
    input  run_gate,
    input  run_gate_n,
    input  fire_rise,
    input  fire_fall,
    input  extend,
    input  ext_clear,
    output pulse_q,
    output pulse_q_n,
    output osc_out
  );

  modport ctl (
    output run_gate,
    output run_gate_n,
    output fire_rise,
    output fire_fall,
    output extend,
    output ext_clear,
    input  pulse_q,
    input  pulse_q_n,
    input  osc_out
  );
endinterface : mapt_link_if

// File: design/mapt_map.svh
`ifndef MAPT_MAP_SVH
`define MAPT_MAP_SVH

// timing figures in hundredths of one timing unit
`define MAPT_OSC_HALF_X100  9'h06E
`define MAPT_SHOT_X100      9'h0F8
`define MAPT_PCT_DIV        32'h0000_0064

// widths
`define MAPT_UNIT_W         16
`define MAPT_CNT_W          24
`define MAPT_SYNC_W         6
`define MAPT_NCNT_W         8

// bit positions inside the synchronised input vector
`define MAPT_B_GATE         0
`define MAPT_B_GATE_N       1
`define MAPT_B_RISE         2
`define MAPT_B_FALL         3
`define MAPT_B_EXTEND       4
`define MAPT_B_CLEAR        5

// reset values and single-step increments
`define MAPT_CNT_ZERO       24'h00_0000
`define MAPT_CNT_ONE        24'h00_0001
`define MAPT_SYNC_IDLE      6'h22
`define MAPT_NCNT_FULL      8'hFF
`define MAPT_NCNT_ONE       8'h01

`endif

// File: design/mapt_pkg.sv
package mapt_pkg;
  `include "mapt_map.svh"

  // gray codes along idle -> astable and idle -> one-shot
  typedef enum logic [1:0] {
    MAPT_IDLE = 2'h0,
    MAPT_ASTB = 2'h1,
    MAPT_SHOT = 2'h2
  } mapt_state_t;

  // how the controlling end wires the timer
  typedef enum logic [2:0] {
    MAPT_M_FREE  = 3'h0,
    MAPT_M_TGATE = 3'h1,
    MAPT_M_CGATE = 3'h2,
    MAPT_M_RISE  = 3'h3,
    MAPT_M_FALL  = 3'h4,
    MAPT_M_RETRG = 3'h5,
    MAPT_M_COUNT = 3'h6
  } mapt_mode_t;

  typedef struct packed {
    logic [`MAPT_SYNC_W-1:0] s1;
    logic [`MAPT_SYNC_W-1:0] s2;
    logic [`MAPT_SYNC_W-1:0] prev;
    mapt_state_t             st;
    logic [`MAPT_CNT_W-1:0]  cnt;
    logic                    osc;
    logic                    q;
    logic                    q_n;
    logic                    busy;
    logic                    retrig;
  } mapt_dev_t;

  typedef struct packed {
    logic                    gate;
    logic                    gate_n;
    logic                    rise;
    logic                    fall;
    logic                    extend;
    logic                    clear;
    logic                    q_prev;
    logic [`MAPT_NCNT_W-1:0] ncnt;
    logic                    done;
  } mapt_ctl_t;
endpackage : mapt_pkg

// File: design/mapt_timer.sv
`timescale 1ns/1ps
`include "mapt_map.svh"
module mapt_timer
  import mapt_pkg::*;
(
  input  wire logic                    core_clk,
  input  wire logic                    rst_n,
  mapt_link_if.dev                     link,
  input  wire logic [`MAPT_UNIT_W-1:0] timing_unit,
  output logic                         busy,
  output logic                         retrig_seen
);
  import mapt_pkg::*;

  mapt_dev_t r;
  mapt_dev_t n;

  // scale the timing unit by a figure in hundredths, never below one cycle
  function automatic logic [`MAPT_CNT_W-1:0] mapt_scale(
    input logic [`MAPT_UNIT_W-1:0] unit,
    input logic [8:0]              x100
  );
    logic [31:0] prod;
    logic [31:0] quot;
    prod = 32'(unit) * 32'(x100);
    quot = prod / `MAPT_PCT_DIV;
    if (quot == 32'h0) begin
      quot = 32'h1;
    end
    return quot[`MAPT_CNT_W-1:0];
  endfunction : mapt_scale

  // one-cycle decrement of a running count
  function automatic logic [`MAPT_CNT_W-1:0] mapt_dec(
    input logic [`MAPT_CNT_W-1:0] cnt
  );
    return cnt - `MAPT_CNT_ONE;
  endfunction : mapt_dec

  // a count that has reached zero ends the current half or pulse
  function automatic logic mapt_expired(
    input logic [`MAPT_CNT_W-1:0] cnt
  );
    return (cnt == `MAPT_CNT_ZERO);
  endfunction : mapt_expired

  // leading edge of one synchronised bit against its previous sample
  function automatic logic mapt_rose(
    input logic [`MAPT_SYNC_W-1:0] now_v,
    input logic [`MAPT_SYNC_W-1:0] was_v,
    input int                      pos
  );
    return now_v[pos] & ~was_v[pos];
  endfunction : mapt_rose

  // trailing edge of one synchronised bit against its previous sample
  function automatic logic mapt_fell(
    input logic [`MAPT_SYNC_W-1:0] now_v,
    input logic [`MAPT_SYNC_W-1:0] was_v,
    input int                      pos
  );
    return ~now_v[pos] & was_v[pos];
  endfunction : mapt_fell

  // decoded view of the synchronised inputs
  logic [`MAPT_SYNC_W-1:0] cur;
  logic [`MAPT_SYNC_W-1:0] old;
  logic [`MAPT_CNT_W-1:0]  half_cnt;
  logic [`MAPT_CNT_W-1:0]  shot_cnt;
  logic                    run;
  logic                    rise_evt;
  logic                    fall_evt;
  logic                    trig;

  // input decode; only the second sync stage and the history are read
  // latency: a pin change after edge k is decoded after edge k+2,
  //   so outputs answer after edge k+3; the extra flops cost latency
  //   but keep a driver from another domain safe
  always_comb begin
    cur      = r.s2;
    old      = r.prev;
    half_cnt = mapt_scale(timing_unit, `MAPT_OSC_HALF_X100) - `MAPT_CNT_ONE;
    shot_cnt = mapt_scale(timing_unit, `MAPT_SHOT_X100) - `MAPT_CNT_ONE;
    run      = cur[`MAPT_B_GATE] | ~cur[`MAPT_B_GATE_N];
    rise_evt = mapt_rose(cur, old, `MAPT_B_RISE) & ~cur[`MAPT_B_FALL];
    fall_evt = mapt_fell(cur, old, `MAPT_B_FALL) & cur[`MAPT_B_RISE];
    trig     = rise_evt | fall_evt;
  end

  // whole next state; clear is evaluated last so it wins over everything
  always_comb begin
    n        = r;
    n.s1     = {link.ext_clear, link.extend, link.fire_fall,
                link.fire_rise, link.run_gate_n, link.run_gate};
    n.s2     = r.s1;
    n.prev   = r.s2;
    n.retrig = 1'b0;
    case (r.st)
      MAPT_IDLE: begin
        if (run) begin
          // oscillation starts with both outputs high, timing begins now
          n.st  = MAPT_ASTB;
          n.cnt = half_cnt;
          n.osc = 1'b1;
          n.q   = 1'b1;
        end else if (trig) begin
          // no dead time: a trigger right after a pulse fires again
          n.st  = MAPT_SHOT;
          n.cnt = shot_cnt;
          n.q   = 1'b1;
        end
      end
      MAPT_ASTB: begin
        if (!run) begin
          // gate gone: stop at once, outputs fall to their idle levels
          n.st  = MAPT_IDLE;
          n.cnt = `MAPT_CNT_ZERO;
          n.osc = 1'b0;
          n.q   = 1'b0;
        end else if (mapt_expired(r.cnt)) begin
          // q turns only on the osc fall, so its period is twice the osc one
          n.cnt = half_cnt;
          n.osc = ~r.osc;
          if (r.osc) begin
            n.q = ~r.q;
          end
        end else begin
          n.cnt = mapt_dec(r.cnt);
        end
      end
      MAPT_SHOT: begin
        if (rise_evt && cur[`MAPT_B_EXTEND]) begin
          // leading edge only; falling edges never reach here
          n.cnt    = shot_cnt;
          n.retrig = 1'b1;
        end else if (mapt_expired(r.cnt)) begin
          // a retrigger ahead of expiry wins above, so the pulse never dips
          n.st = MAPT_IDLE;
          n.q  = 1'b0;
        end else begin
          n.cnt = mapt_dec(r.cnt);
        end
      end
      // unused code: fall back to idle with everything low
      default: begin
        n.st  = MAPT_IDLE;
        n.cnt = `MAPT_CNT_ZERO;
        n.osc = 1'b0;
        n.q   = 1'b0;
      end
    endcase
    // clear is the final word; it also wipes a pending retrigger flag
    if (cur[`MAPT_B_CLEAR]) begin
      n.st     = MAPT_IDLE;
      n.cnt    = `MAPT_CNT_ZERO;
      n.osc    = 1'b0;
      n.q      = 1'b0;
      n.retrig = 1'b0;
    end
    // the complement is derived from the same next value, never separately
    n.q_n  = ~n.q;
    n.busy = (n.st != MAPT_IDLE);
  end

  // single state register; reset matches the cleared state
  // limitation: timing_unit is read live, so change it only when idle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      r.s1     <= `MAPT_SYNC_IDLE;
      r.s2     <= `MAPT_SYNC_IDLE;
      r.prev   <= `MAPT_SYNC_IDLE;
      r.st     <= MAPT_IDLE;
      r.cnt    <= `MAPT_CNT_ZERO;
      r.osc    <= 1'b0;
      r.q      <= 1'b0;
      r.q_n    <= 1'b1;
      r.busy   <= 1'b0;
      r.retrig <= 1'b0;
    end else begin
      r <= n;
    end
  end

  // outputs straight from flops
  assign link.pulse_q   = r.q;
  assign link.pulse_q_n = r.q_n;
  assign link.osc_out   = r.osc;
  assign busy           = r.busy;
  assign retrig_seen    = r.retrig;
endmodule : mapt_timer

// File: verification/mapt_chk_sva.sv
`timescale 1ns/1ps
module mapt_chk_sva #(
  parameter int H = 11,
  parameter int W = 24
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic run_gate,
  input wire logic run_gate_n,
  input wire logic fire_rise,
  input wire logic fire_fall,
  input wire logic extend,
  input wire logic ext_clear,
  input wire logic pulse_q,
  input wire logic pulse_q_n,
  input wire logic osc_out,
  input wire logic retrig_seen
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  logic gate_on;
  logic fr_d;
  logic odd;
  int   gcnt;
  int   qrun;
  int   orun;
  int   age;
  int   hold;
  // gate as the timer decodes it, either polarity
  assign gate_on = run_gate | ~run_gate_n;
  // run lengths and guards; odd marks a pulse that was not one clean shot
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fr_d <= 1'h0;
      odd  <= 1'h0;
      gcnt <= 0;
      qrun <= 0;
      orun <= 0;
      age  <= 0;
      hold <= 0;
    end else begin
      fr_d <= fire_rise;
      odd  <= (pulse_q & odd) | osc_out | gate_on | extend | ext_clear;
      gcnt <= (gate_on && !ext_clear) ? gcnt + 1 : 0;
      qrun <= pulse_q ? qrun + 1 : 0;
      orun <= osc_out ? orun + 1 : 0;
      age  <= (pulse_q && !retrig_seen) ? age + 1 : 0;
      // only retriggers that land before the old pulse ends are judged
      if (ext_clear)
        hold <= 0;
      else if (fire_rise && !fr_d && extend && pulse_q && age + 4 < W)
        hold <= W + 1;
      else if (hold > 0)
        hold <= hold - 1;
    end
  end
  a_pulse_pair: assert property (pulse_q_n == ~pulse_q)
    else $error("pulse outputs not complementary");
  a_clear_idle: assert property (ext_clear [*3] |=> !pulse_q && !osc_out)
    else $error("clear did not force idle");
  a_rise_fire: assert property ($rose(fire_rise) && !fire_fall && !pulse_q && !osc_out && !gate_on
    && !ext_clear ##1 !ext_clear [*2] |=> pulse_q)
    else $error("rising trigger gave no pulse");
  a_fall_fire: assert property ($fell(fire_fall) && fire_rise && !pulse_q && !osc_out && !gate_on
    && !ext_clear ##1 !ext_clear [*2] |=> pulse_q)
    else $error("falling trigger gave no pulse");
  a_shot_width: assert property ($fell(pulse_q) && !odd |-> qrun == W)
    else $error("one-shot width wrong");
  a_osc_half: assert property ($fell(osc_out) && gcnt > H + 4 |-> orun == H)
    else $error("oscillator half period wrong");
  a_q_half: assert property ($fell(pulse_q) && gcnt > 2 * H + 4 |-> qrun == 2 * H)
    else $error("astable pulse half period wrong");
  a_retrig_hold: assert property (hold > 0 |-> pulse_q)
    else $error("retriggered pulse dropped");
  c_shot: cover property ($fell(pulse_q) && !odd);
  c_retrig: cover property (hold == 1);
  c_osc: cover property ($fell(osc_out) && gcnt > H + 4);
endmodule : mapt_chk_sva

// File: verification/mono_astable_pulse_timer_tb_top.sv
`timescale 1ns/1ps
`include "mapt_map.svh"
module mono_astable_pulse_timer_tb_top;
  import mapt_pkg::*;
  localparam int H = 11;
  localparam int W = 24;
  logic                    core_clk;
  logic                    rst_n;
  logic [`MAPT_UNIT_W-1:0] timing_unit;
  mapt_mode_t              user_mode;
  mapt_mode_t              md;
  logic                    user_run;
  logic                    user_fire;
  logic                    user_clear;
  logic [`MAPT_NCNT_W-1:0] count_n;
  logic                    busy;
  logic                    retrig_seen;
  logic                    count_done;
  logic                    qd;
  int                      n_fail;
  int                      n_compared;
  int                      n_rt;
  int                      n;
  int                      k;
  mapt_link_if link ();
  mapt_timer mapt_timer_inst (.core_clk(core_clk), .rst_n(rst_n), .link(link), .timing_unit(timing_unit),
    .busy(busy), .retrig_seen(retrig_seen));
  mapt_ctl mapt_ctl_inst (.core_clk(core_clk), .rst_n(rst_n), .link(link), .user_mode(user_mode),
    .user_run(user_run), .user_fire(user_fire), .user_clear(user_clear), .count_n(count_n),
    .count_done(count_done));
  mapt_chk_sva #(.H(H), .W(W)) mapt_chk_sva_inst (.core_clk(core_clk), .rst_n(rst_n),
    .run_gate(link.run_gate), .run_gate_n(link.run_gate_n), .fire_rise(link.fire_rise),
    .fire_fall(link.fire_fall), .extend(link.extend), .ext_clear(link.ext_clear),
    .pulse_q(link.pulse_q), .pulse_q_n(link.pulse_q_n), .osc_out(link.osc_out),
    .retrig_seen(retrig_seen));
  // 40 MHz
  initial begin
    core_clk = 1'h0;
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic cyc(input int c);
    repeat (c) @(negedge core_clk);
  endtask : cyc
  task automatic chk_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %0t bit %b exp %b", $time, got, exp);
    end
  endtask : chk_bit
  task automatic chk_num(input int got, input int exp);
    n_compared++;
    if (got != exp) begin
      n_fail++;
      $display("FAIL %0t count %0d exp %0d", $time, got, exp);
    end
  endtask : chk_num
  // user side request: run, fire, clear as one vector, held a full cycle
  task automatic drive(input mapt_mode_t m, input logic [2:0] rfc);
    user_mode = m;
    {user_run, user_fire, user_clear} = rfc;
    cyc(1);
  endtask : drive
  // high run length of osc_out or pulse_q, complement checked on the way
  task automatic meas(input logic use_osc, output int len);
    len = 0;
    for (k = 0; k < 100 && (use_osc ? link.osc_out : link.pulse_q) !== 1'h1; k++)
      cyc(1);
    while ((use_osc ? link.osc_out : link.pulse_q) === 1'h1 && len < 400) begin
      chk_bit(link.pulse_q_n, ~link.pulse_q);
      len++;
      cyc(1);
    end
  endtask : meas
  task automatic results();
    if (n_fail == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results
  // retrigger pulses seen at the timer
  always @(posedge core_clk) begin
    if (retrig_seen === 1'h1)
      n_rt++;
  end
  // watchdog: the sequence needs under two thousand cycles
  initial begin
    cyc(5000);
    n_fail++;
    $display("FAIL %0t watchdog", $time);
    results();
  end
  // reset, one-shot, retrigger, clear, astable, gating, countdown
  initial begin
    timing_unit = 16'h000A;
    count_n = 8'h03;
    n_fail = 0;
    n_compared = 0;
    n_rt = 0;
    rst_n = 1'h0;
    qd = 1'h0;
    drive(MAPT_M_RISE, 3'h1);
    cyc(2);
    chk_bit(link.pulse_q_n, 1'h1);
    chk_bit(link.osc_out, 1'h0);
    chk_bit(count_done, 1'h1);
    rst_n = 1'h1;
    drive(MAPT_M_RISE, 3'h0);
    cyc(6);
    drive(MAPT_M_RISE, 3'h2);
    drive(MAPT_M_RISE, 3'h0);
    meas(1'h0, n);
    chk_num(n, W);
    drive(MAPT_M_RISE, 3'h2);
    meas(1'h0, n);
    chk_num(n, W);
    drive(MAPT_M_RISE, 3'h0);
    drive(MAPT_M_RISE, 3'h2);
    meas(1'h0, n);
    chk_num(n, W);
    drive(MAPT_M_FALL, 3'h0);
    cyc(40);
    drive(MAPT_M_FALL, 3'h2);
    cyc(5);
    chk_bit(link.pulse_q, 1'h0);
    drive(MAPT_M_FALL, 3'h0);
    meas(1'h0, n);
    chk_num(n, W);
    drive(MAPT_M_RETRG, 3'h0);
    cyc(40);
    n_rt = 0;
    for (int i = 0; i < 6; i++) begin
      drive(MAPT_M_RETRG, 3'h2);
      cyc(1);
      drive(MAPT_M_RETRG, 3'h0);
      cyc(7);
      if (i > 0)
        chk_bit(link.pulse_q, 1'h1);
    end
    meas(1'h0, n);
    chk_num(n, W - 6);
    chk_num(n_rt, 5);
    drive(MAPT_M_RISE, 3'h2);
    cyc(6);
    chk_bit(link.pulse_q, 1'h1);
    drive(MAPT_M_RISE, 3'h1);
    cyc(4);
    chk_bit(link.pulse_q | busy, 1'h0);
    drive(MAPT_M_RISE, 3'h3);
    cyc(10);
    chk_bit(link.pulse_q, 1'h0);
    drive(MAPT_M_RISE, 3'h0);
    cyc(8);
    chk_bit(link.pulse_q | busy, 1'h0);
    drive(MAPT_M_FREE, 3'h0);
    meas(1'h1, n);
    meas(1'h1, n);
    chk_num(n, H);
    meas(1'h0, n);
    chk_num(n, 2 * H);
    for (int i = 0; i < 2; i++) begin
      md = i ? MAPT_M_CGATE : MAPT_M_TGATE;
      drive(md, 3'h0);
      cyc(6);
      chk_bit(link.osc_out | link.pulse_q, 1'h0);
      drive(md, 3'h4);
      cyc(6);
      chk_bit(link.pulse_q & busy, 1'h1);
    end
    drive(MAPT_M_COUNT, 3'h0);
    cyc(6);
    chk_bit(link.osc_out | link.pulse_q, 1'h0);
    drive(MAPT_M_COUNT, 3'h2);
    drive(MAPT_M_COUNT, 3'h0);
    n = 0;
    for (k = 0; k < 9 && count_done !== 1'h0; k++)
      cyc(1);
    // every rise of the pulse output clocks the outside counter once
    for (k = 0; k < 900 && count_done !== 1'h1; k++) begin
      n += (link.pulse_q === 1'h1 && qd !== 1'h1);
      qd = link.pulse_q;
      cyc(1);
    end
    cyc(6);
    chk_bit(link.pulse_q, 1'h0);
    chk_num(n, count_n + 1);
    results();
  end
endmodule : mono_astable_pulse_timer_tb_top
